// File: hw/sbs_fifo.sv
// Parameterised flip-flop FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none

module sbs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             mclk_i,
    input  wire logic             resetn_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    import sbs_pkg::*;

    localparam int PTR_W = $clog2(DEPTH);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration check
    if (DEPTH < 2 || (1 << PTR_W) != DEPTH || WIDTH < 1) begin : g_bad_cfg
        $error("sbs_fifo: depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W:0]   wr_ptr;
    logic [PTR_W:0]   rd_ptr;
    logic             push;
    logic             pop;

    ////////////////////////////////////////////////////////////////////////
    // Honest full and empty from pointers with a wrap bit
    assign out_valid_o = (wr_ptr != rd_ptr);
    assign in_ready_o  = (wr_ptr[PTR_W-1:0] != rd_ptr[PTR_W-1:0])
                         || (wr_ptr[PTR_W] == rd_ptr[PTR_W]);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = store[rd_ptr[PTR_W-1:0]];

    // Entry storage
    always_ff @(posedge mclk_i) begin
        if (push) begin
            store[wr_ptr[PTR_W-1:0]] <= in_data_i;
        end
    end

    // Write pointer
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            wr_ptr <= '0;
        end else if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    // Read pointer
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            rd_ptr <= '0;
        end else if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end

    // Occupancy never exceeds depth
    a_fifo_bound: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (wr_ptr - rd_ptr) <= (PTR_W+1)'(DEPTH))
        else $error("fifo occupancy beyond depth");

endmodule : sbs_fifo

`default_nettype wire

// File: hw/sbs_pkg.sv
// Shared constants for the synchronous burst static RAM interface
package sbs_pkg;

    // Byte lane layout: eight data bits plus one parity bit
    localparam int LANE_DATA_W  = 8;
    localparam int LANE_W       = 9;
    localparam int PAR_POS      = 8;

    // Organisations: wide word with four lanes, narrow word with two
    localparam int WIDE_LANES   = 4;
    localparam int WIDE_ADDR_W  = 17;
    localparam int NARROW_LANES = 2;
    localparam int NARROW_ADDR_W = 18;

    // Burst counter acts on the two low address bits
    localparam int BURST_CNT_W  = 2;
    localparam int BURST_LEN    = 4;
    localparam logic [1:0] BURST_CNT_RST = 2'h0;
    localparam logic       SEL_RST       = 1'b0;

    // Write queue between input register and array
    localparam int WQ_DEPTH     = 16;

endpackage : sbs_pkg

// File: hw/sbs_sram_if.sv
// Synchronous burst static RAM: address, burst, write and output control
`timescale 1ns/100ps
`default_nettype none

// What this block does
// (R01) Offers 128K words of 36 bits or 256K words of 18 bits.
// (R02) Address loads on controller strobe low, or processor strobe low with primary select.
// (R03) Burst step low advances the burst counter; high holds it.
// (R04) One loaded address yields up to four data cycles.
// (R05) Order select high means interleaved, low means linear; static, not clocked.
// (R06) Controller keeps the order select constant during operation; the bench changes it between bursts.
// (R07) Counter wraps in four words: linear adds, interleaved XORs the low bits.
// (R08) Lane gate low lets lane selects act; high blocks them.
// (R09) Whole-word write low writes every lane, overriding lane selects and gate.
// (R10) Each lane select covers eight data bits plus one parity bit, lane one lowest.
// (R11) Any active lane write turns off all data drivers.
// (R12) Selected only with primary select low, high select high, low select low.
// (R13) Write data captured in an input register on the rising edge.
// (R14) Read data flows from array to pins without an output register.
// (R15) Output enable low and selected drives pins; high releases them at once.
// (R16) Writes complete internally, self-timed, after the write cycle.
// (R17) Sleep high blocks the internal clock for lowest power.
// (R18) Sleep keeps all stored contents.
// (R19) Unconnected sleep pin leaves the device always active.
// (R20) Undriven order select means interleaved; undriven sleep means active.
module sbs_sram_if #(
    parameter int LANES        = sbs_pkg::WIDE_LANES,
    parameter int ADDR_W       = sbs_pkg::WIDE_ADDR_W,
    parameter bit ORDER_PIN_ON = 1'b1,
    parameter bit SLEEP_PIN_ON = 1'b1
) (
    input  wire logic                 mclk_i,
    input  wire logic                 resetn_i,
    input  wire logic [ADDR_W-1:0]    addr_in_i,
    input  wire logic                 ctrl_addr_strobe_n_i,
    input  wire logic                 proc_addr_strobe_n_i,
    input  wire logic                 chip_en_n_i,
    input  wire logic                 select_high_i,
    input  wire logic                 select_low_n_i,
    input  wire logic                 burst_step_n_i,
    input  wire logic                 burst_order_sel_i,
    input  wire logic                 lane_write_gate_n_i,
    input  wire logic [LANES-1:0]     lane_write_sel_n_i,
    input  wire logic                 whole_word_write_n_i,
    input  wire logic                 out_en_n_i,
    input  wire logic                 sleep_request_i,
    input  wire logic [LANES*8-1:0]   data_pins_i,
    input  wire logic [LANES-1:0]     parity_bits_i,
    output logic      [LANES*8-1:0]   data_pins_o,
    output logic      [LANES-1:0]     parity_bits_o,
    output logic                      data_pins_oe_o,
    output logic                      write_ready_o,
    output logic                      sleeping_o
);
    import sbs_pkg::*;

    localparam int WORD_W  = LANES * LANE_W;
    localparam int DATA_W  = LANES * LANE_DATA_W;
    localparam int DEPTH   = 1 << ADDR_W;
    localparam int ENTRY_W = ADDR_W + LANES + WORD_W;
    localparam int MAX_AW  = (LANES == WIDE_LANES) ? WIDE_ADDR_W : NARROW_ADDR_W;

    ////////////////////////////////////////////////////////////////////////
    // Elaboration check on organisation
    if (!(LANES == WIDE_LANES || LANES == NARROW_LANES)
        || ADDR_W < BURST_CNT_W || ADDR_W > MAX_AW) begin : g_bad_org // R01
        $error("sbs_sram_if: only four or two lanes with a fitting address width");
    end

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [WORD_W-1:0]      mem [DEPTH];
    logic [ADDR_W-1:0]      base_addr;
    logic [1:0]             burst_cnt;
    logic                   selected;
    logic                   run;
    logic                   sleep_eff;
    logic                   interleaved;
    logic                   load;
    logic                   decode_sel;
    logic [1:0]             low_bits;
    logic [ADDR_W-1:0]      cur_addr;
    logic [ADDR_W-1:0]      next_wr_addr;
    logic                   sel_now;
    logic [LANES-1:0]       wr_mask;
    logic                   write_active;
    logic [WORD_W-1:0]      in_word;
    logic                   wq_in_valid;
    logic                   wq_in_ready;
    logic                   wq_out_valid;
    logic                   wq_out_ready;
    logic [ENTRY_W-1:0]     wq_out_data;
    logic [ADDR_W-1:0]      drain_addr;
    logic [LANES-1:0]       drain_mask;
    logic [WORD_W-1:0]      drain_word;
    logic [WORD_W-1:0]      merged_word;
    logic [WORD_W-1:0]      read_word;

    ////////////////////////////////////////////////////////////////////////
    // Strap defaults for unconnected sleep and order pins
    assign sleep_eff   = SLEEP_PIN_ON ? sleep_request_i : 1'b0;       // R19
    assign interleaved = ORDER_PIN_ON ? burst_order_sel_i : 1'b1;     // R20

    // Sleep blocks every state update, array and queue included
    assign run        = !sleep_eff;                                   // R17
    assign sleeping_o = sleep_eff;

    ////////////////////////////////////////////////////////////////////////
    // Address strobes; processor strobe qualified by primary select
    assign load = !ctrl_addr_strobe_n_i
                  || (!proc_addr_strobe_n_i && !chip_en_n_i);          // R02

    // Three-part select decode
    assign decode_sel = !chip_en_n_i && select_high_i && !select_low_n_i; // R12

    // Base address register
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            base_addr <= '0;
        end else if (run && load) begin
            base_addr <= addr_in_i;                                   // R02
        end
    end

    // Selection captured with each new address
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            selected <= SEL_RST;
        end else if (run && load) begin
            selected <= decode_sel;                                   // R12
        end
    end

    // Burst counter: clears on load, steps on burst step low
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            burst_cnt <= BURST_CNT_RST;
        end else if (run) begin
            if (load) begin
                burst_cnt <= BURST_CNT_RST;                           // R04
            end else if (!burst_step_n_i) begin
                burst_cnt <= burst_cnt + 2'h1;                        // R03
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Burst order within a four-word block, steered by the static select
    always_comb begin
        if (interleaved) begin
            low_bits = base_addr[1:0] ^ burst_cnt;                    // R05 R07
        end else begin
            low_bits = base_addr[1:0] + burst_cnt;                    // R07
        end
    end

    if (ADDR_W > BURST_CNT_W) begin : g_cur_addr
        assign cur_addr = {base_addr[ADDR_W-1:BURST_CNT_W], low_bits};
    end else begin : g_cur_addr_small
        assign cur_addr = low_bits[ADDR_W-1:0];
    end

    // Write target: fresh address on a load edge, burst address otherwise
    assign next_wr_addr = load ? addr_in_i : cur_addr;
    assign sel_now      = load ? decode_sel : selected;

    ////////////////////////////////////////////////////////////////////////
    // Lane write mask: whole word overrides, gate blocks lane selects
    always_comb begin
        if (!whole_word_write_n_i) begin
            wr_mask = '1;                                             // R09
        end else if (!lane_write_gate_n_i) begin
            wr_mask = ~lane_write_sel_n_i;                            // R08
        end else begin
            wr_mask = '0;                                             // R08
        end
    end

    assign write_active = sel_now && (wr_mask != '0);

    // Lane packing: eight data bits and parity per lane, lane one lowest
    for (genvar k = 0; k < LANES; k++) begin : g_lane
        assign in_word[k*LANE_W +: LANE_DATA_W] =
            data_pins_i[k*LANE_DATA_W +: LANE_DATA_W];                // R10
        assign in_word[k*LANE_W + PAR_POS] = parity_bits_i[k];        // R10
        assign merged_word[k*LANE_W +: LANE_W] = drain_mask[k]
            ? drain_word[k*LANE_W +: LANE_W]
            : mem[drain_addr][k*LANE_W +: LANE_W];                    // R10
        assign data_pins_o[k*LANE_DATA_W +: LANE_DATA_W] =
            read_word[k*LANE_W +: LANE_DATA_W];
        assign parity_bits_o[k] = read_word[k*LANE_W + PAR_POS];
    end

    ////////////////////////////////////////////////////////////////////////
    // Input register is the queue entry; write data taken at the edge
    assign wq_in_valid   = run && write_active;                       // R13
    assign write_ready_o = wq_in_ready;
    assign wq_out_ready  = run;                                       // R18

    sbs_fifo #(
        .WIDTH (ENTRY_W),
        .DEPTH (WQ_DEPTH)
    ) u_write_queue (
        .mclk_i      (mclk_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (wq_in_valid),
        .in_ready_o  (wq_in_ready),
        .in_data_i   ({next_wr_addr, wr_mask, in_word}),
        .out_valid_o (wq_out_valid),
        .out_ready_i (wq_out_ready),
        .out_data_o  (wq_out_data)
    );

    assign {drain_addr, drain_mask, drain_word} = wq_out_data;

    // Self-timed array write, one queued entry per cycle while awake
    always_ff @(posedge mclk_i) begin
        if (wq_out_valid && wq_out_ready) begin
            mem[drain_addr] <= merged_word;                           // R16 R18
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flow-through read path straight from the array
    assign read_word = mem[cur_addr];                                 // R14

    // Output drivers: enable low and selected, never during a lane write
    assign data_pins_oe_o = !out_en_n_i && selected && !write_active; // R15 R11

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_addr_load_edge: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R02
        (run && load) |=> (base_addr == $past(addr_in_i) && burst_cnt == 2'h0))
        else $error("address not loaded on strobe");

    a_burst_holds: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R03
        (run && !load && burst_step_n_i) |=> $stable(burst_cnt))
        else $error("burst counter moved without step");

    a_burst_four_beats: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R04
        (run && load) ##1 (run && !load && !burst_step_n_i) [*3]
        |=> (burst_cnt == 2'h3))
        else $error("burst did not reach fourth beat");

    a_order_linear: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R07
        !interleaved |-> (cur_addr[1:0] == 2'(base_addr[1:0] + burst_cnt)))
        else $error("linear order wrong");

    a_order_interleave: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R05
        interleaved |-> (cur_addr[1:0] == (base_addr[1:0] ^ burst_cnt)))
        else $error("interleaved order wrong");

    a_gate_blocks_lanes: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R08
        (lane_write_gate_n_i && whole_word_write_n_i) |-> !write_active)
        else $error("lane selects acted while gate high");

    a_whole_word_all: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R09
        (run && sel_now && !whole_word_write_n_i && wq_in_ready)
        |-> (wq_in_valid && wr_mask == {LANES{1'b1}}))
        else $error("whole word write missed a lane");

    a_no_drive_on_write: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R11
        write_active |-> !data_pins_oe_o)
        else $error("drivers on during write");

    a_select_decode: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R12
        (run && load) |=> (selected == $past(decode_sel)))
        else $error("select not decoded from all three inputs");

    a_capture_data: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R13
        wq_in_valid && wq_in_ready && !wq_out_valid
        |=> (wq_out_valid && drain_word == $past(in_word)
             && drain_addr == $past(next_wr_addr)))
        else $error("write data not captured at edge");

    a_sleep_freezes: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R17
        sleep_eff |=> ($stable(base_addr) && $stable(burst_cnt) && $stable(selected)))
        else $error("state changed while asleep");

    a_drive_needs_oe: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R15
        out_en_n_i |-> !data_pins_oe_o)
        else $error("pins driven with output enable high");

endmodule : sbs_sram_if

`default_nettype wire

// File: test/sbs_bus_model.sv
// Behavioural memory-bus controller driving the burst static RAM pins
`timescale 1ns/100ps
`default_nettype none

module sbs_bus_model (
    input  wire logic        mclk_i,
    input  wire logic [35:0] dut_q_i,
    input  wire logic        dut_oe_i,
    output logic      [5:0]  addr_o,
    output logic      [5:0]  strb_o,
    output logic      [3:0]  lane_n_o,
    output logic      [4:0]  stat_o,
    output logic      [35:0] wire_o
);
    logic [35:0] wd;
    logic [35:0] last;
    logic        drv;

    ////////////////////////////////////////
    // Idle levels at time zero, order select high
    initial begin
        strb_o = 6'h37;
        lane_n_o = 4'hf;
        addr_o = 6'h0;
        stat_o = 5'h11;
        wd = 36'h0;
        drv = 1'b0;
        last = 36'h0;
    end

    // Resolved pin level; a released bus shows a changing pattern
    assign wire_o = drv ? wd : (dut_oe_i ? dut_q_i : ~last);
    always @(posedge mclk_i) begin
        last <= wire_o;
    end

    // One bus cycle, launched just after the rising edge
    task automatic cyc(input logic [5:0] s, input logic [3:0] ln, input logic [5:0] a,
                       input logic [35:0] d);
        @(posedge mclk_i);
        strb_o <= s;
        lane_n_o <= ln;
        addr_o <= a;
        wd <= d;
        drv <= !s[1] || (!s[0] && ln != 4'hf);
    endtask : cyc

    // Static levels; the bench changes order only between bursts
    task automatic stat(input logic [4:0] v);
        @(posedge mclk_i);
        stat_o <= v;
    endtask : stat
endmodule : sbs_bus_model
`default_nettype wire

// File: test/tb_sync_burst_sram_interface.sv
// Self-checking bench for the burst static RAM interface and its write queue
`timescale 1ns/100ps
`default_nettype none

module tb_sync_burst_sram_interface;
    import sbs_pkg::*;
    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    logic        ord = 1'b1;
    logic [31:0] rng = 32'h0000557f;
    logic [5:0]  addr;
    logic [5:0]  strb;
    logic [3:0]  lane_n;
    logic [4:0]  stat;
    logic [35:0] pins;
    logic [31:0] q;
    logic [3:0]  qp;
    logic        oe, wr_rdy, slp;
    logic [35:0] mem [64];
    int          n_errors = 0;
    int          num_checks = 0;
    int          cycles = 0;

    ////////////////////////////////////////
    sbs_bus_model u_sbs_bus_model (.mclk_i(mclk), .dut_q_i({qp, q}), .dut_oe_i(oe),
        .addr_o(addr), .strb_o(strb), .lane_n_o(lane_n), .stat_o(stat), .wire_o(pins));
    sbs_sram_if #(.ADDR_W(6)) u_sbs_sram_if (.mclk_i(mclk), .resetn_i(resetn),
        .addr_in_i(addr), .ctrl_addr_strobe_n_i(strb[5]), .proc_addr_strobe_n_i(strb[4]),
        .chip_en_n_i(strb[3]), .select_high_i(stat[4]), .select_low_n_i(stat[3]),
        .burst_step_n_i(strb[2]), .burst_order_sel_i(stat[0]),
        .lane_write_gate_n_i(strb[0]), .lane_write_sel_n_i(lane_n),
        .whole_word_write_n_i(strb[1]), .out_en_n_i(stat[2]), .sleep_request_i(stat[1]),
        .data_pins_i(pins[31:0]), .parity_bits_i(pins[35:32]), .data_pins_o(q),
        .parity_bits_o(qp), .data_pins_oe_o(oe), .write_ready_o(wr_rdy), .sleeping_o(slp));

    // Clock and hang guard
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic chk_w(input logic [35:0] got, input logic [35:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_w

    task automatic chk_f(input logic got, input logic exp);
        chk_w({35'h0, got}, {35'h0, exp});
    endtask : chk_f

    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xs

    function automatic logic [35:0] rw();
        logic [63:0] v;
        v = {xs(), xs()};
        return v[35:0];
    endfunction : rw

    // Burst address: wrap in four words, add or exclusive-or
    function automatic logic [5:0] ba(input logic [5:0] b, input logic [1:0] c, input logic o);
        return o ? {b[5:2], b[1:0] ^ c} : {b[5:2], b[1:0] + c};
    endfunction : ba

    task automatic idle(input int n);
        repeat (n) u_sbs_bus_model.cyc(6'h37, 4'hf, 6'h0, 36'h0);
    endtask : idle

    // Write cycle on its own load; lane k is data byte k plus parity bit k
    task automatic wr(input logic [5:0] a, input logic [35:0] d, input logic g, input logic b,
                      input logic [3:0] ln);
        logic [3:0] m;
        m = !g ? 4'hf : (!b ? ~ln : 4'h0);
        u_sbs_bus_model.cyc({4'h5, g, b}, ln, a, d);
        #1 chk_f(oe, m == 4'h0);
        for (int k = 0; k < 4; k++) begin
            if (m[k]) begin
                mem[a][8*k +: 8] = d[8*k +: 8];
                mem[a][32+k] = d[32+k];
            end
        end
    endtask : wr

    // Read burst of four beats, then one hold cycle; p picks the processor strobe
    task automatic rd(input logic [5:0] a, input logic p);
        logic [1:0] c = 2'h0;
        logic [4:0] st = 5'b11000;
        u_sbs_bus_model.cyc(p ? 6'h27 : 6'h17, 4'hf, a, 36'h0);
        for (int j = 0; j < 5; j++) begin
            u_sbs_bus_model.cyc({3'b110, st[j], 2'b11}, 4'hf, a, 36'h0);
            #1 chk_w({qp, q}, mem[ba(a, c, ord)]);
            chk_f(oe, 1'b1);
            c = c + {1'b0, !st[j]};
        end
    endtask : rd

    ////////////////////////////////////////
    initial begin
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        #1 chk_f(oe, 1'b0);
        chk_f(wr_rdy, 1'b1);
        for (int i = 8; i < 16; i++) begin
            wr(6'(i), rw(), 1'b0, 1'b1, 4'(xs()));
        end
        idle(2);
        #1 chk_f(wr_rdy, 1'b1);
        for (int o = 0; o < 2; o++) begin
            ord = o[0];
            u_sbs_bus_model.stat({4'h8, ord});
            rd(6'h8 + 6'(xs() % 8), o[0]);
        end
        for (int k = 0; k < 4; k++) begin
            wr(6'h8 + 6'(k), rw(), 1'b1, 1'b0, 4'(xs()));
        end
        wr(6'hc, rw(), 1'b1, 1'b1, 4'h0);
        wr(6'hd, rw(), 1'b0, 1'b1, 4'h5);
        idle(2);
        rd(6'h8, 1'b1);
        rd(6'hc, 1'b0);
        u_sbs_bus_model.cyc(6'h2f, 4'hf, 6'h3, 36'h0);
        idle(1);
        #1 chk_w({qp, q}, mem[ba(6'hc, 2'h3, ord)]);
        for (int k = 0; k < 3; k++) begin
            u_sbs_bus_model.stat(k == 0 ? 5'h01 : (k == 1 ? 5'h19 : 5'h11));
            u_sbs_bus_model.cyc(k == 2 ? 6'h1f : 6'h17, 4'hf, 6'h8, 36'h0);
            idle(1);
            #1 chk_f(oe, 1'b0);
        end
        rd(6'ha, 1'b0);
        u_sbs_bus_model.stat(5'h15);
        idle(1);
        #1 chk_f(oe, 1'b0);
        u_sbs_bus_model.stat(5'h13);
        idle(1);
        #1 chk_f(slp, 1'b1);
        u_sbs_bus_model.cyc(6'h15, 4'hf, 6'h8, rw());
        idle(2);
        u_sbs_bus_model.stat(5'h11);
        idle(2);
        #1 chk_f(slp, 1'b0);
        rd(6'h8, 1'b0);
        // Write queue through the top: sixteen back-to-back writes, then read back
        for (int i = 0; i < 16; i++) begin
            wr(6'h20 + 6'(i), rw(), 1'b0, 1'b1, 4'hf);
            chk_f(wr_rdy, 1'b1);
        end
        idle(2);
        #1 chk_f(wr_rdy, 1'b1);
        for (int b = 0; b < 4; b++) begin
            ord = b[1];
            u_sbs_bus_model.stat({4'h8, ord});
            rd(6'h20 + 6'(4 * b + b), b[0]);
        end
        summarize();
    end
endmodule : tb_sync_burst_sram_interface
`default_nettype wire
